// file: rtl/fl_pkg.sv
// shared constants, types and lane helpers for the flash link
package fl_pkg;
  // =====================================================
  // protocols, frame phases and opcodes
  typedef enum logic [1:0] {
    EXTENDED_LANE_PROTOCOL = 2'b00,
    TWO_LANE_PROTOCOL = 2'b01,
    FOUR_LANE_PROTOCOL = 2'b10
  } fl_proto_e;
  typedef enum logic [2:0] {
    PH_CMD = 3'b000,
    PH_ADDR = 3'b001,
    PH_DIN = 3'b010,
    PH_DOUT = 3'b011,
    PH_DONE = 3'b100
  } fl_phase_e;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUTPUT_FAST_READ = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO_FAST_READ = 8'heb;
  // =====================================================
  // field widths and positions
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h20;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam int ADDR_W = 25;
  localparam int SECTOR_LSB = 16;
  localparam int SUB32_LSB = 15;
  localparam int SUB4_LSB = 12;
  localparam int SR_SRWD_BIT = 7;
  localparam int SR_WEL_BIT = 1;
  localparam logic [7:0] SR_NV_MASK = 8'hfc;
  localparam logic [7:0] SR_RESET = 8'h00;
  // =====================================================
  // host register map
  localparam logic [7:0] RG_CMD = 8'h00;
  localparam logic [7:0] RG_ADDR = 8'h04;
  localparam logic [7:0] RG_WDATA = 8'h08;
  localparam logic [7:0] RG_CFG = 8'h0c;
  localparam logic [7:0] RG_STAT = 8'h10;
  localparam logic [7:0] RG_RDATA = 8'h14;
  localparam int CFG_WP_BIT = 2;
  localparam int CFG_LEN_LSB = 3;
  // =====================================================
  // lane width of a phase
  function automatic logic [2:0] fl_width(logic [1:0] proto, logic [7:0] op, fl_phase_e ph);
    logic [2:0] w;
    w = 3'h1;
    if (proto == TWO_LANE_PROTOCOL) w = 3'h2;
    else if (proto == FOUR_LANE_PROTOCOL) w = 3'h4;
    else if (ph == PH_ADDR && op == OP_DUAL_IO_READ) w = 3'h2;
    else if (ph == PH_ADDR && op == OP_QUAD_IO_FAST_READ) w = 3'h4;
    else if (ph == PH_DOUT && op == OP_DUAL_IO_READ) w = 3'h2;
    else if (ph == PH_DOUT && (op == OP_QUAD_OUTPUT_FAST_READ || op == OP_QUAD_IO_FAST_READ)) w = 3'h4;
    return w;
  endfunction : fl_width
  // phase that follows the opcode
  function automatic fl_phase_e fl_after_cmd(logic [7:0] op);
    fl_phase_e p;
    case (op)
      OP_READ, OP_DUAL_IO_READ, OP_QUAD_OUTPUT_FAST_READ, OP_QUAD_IO_FAST_READ: p = PH_ADDR;
      OP_READ_STATUS: p = PH_DOUT;
      OP_WRITE_STATUS: p = PH_DIN;
      default: p = PH_DONE;
    endcase
    return p;
  endfunction : fl_after_cmd
  // bits in one unit of a phase
  function automatic logic [5:0] fl_unit_bits(fl_phase_e ph);
    return (ph == PH_ADDR) ? ADDR_BITS : (ph == PH_CMD) ? CMD_BITS : BYTE_BITS;
  endfunction : fl_unit_bits
  // lanes used; single lane is lane 0 from host, lane 1 from device
  function automatic logic [3:0] fl_mask(logic [2:0] w, logic dev);
    return (w == 3'h4) ? 4'hf : (w == 3'h2) ? 4'h3 : (dev ? 4'h2 : 4'h1);
  endfunction : fl_mask
  // right-aligned bits taken from the lanes
  function automatic logic [3:0] fl_pick(logic [3:0] dq, logic [2:0] w, logic dev);
    return (w == 3'h4) ? dq : (w == 3'h2) ? {2'h0, dq[1:0]} : {3'h0, dev ? dq[1] : dq[0]};
  endfunction : fl_pick
  // right-aligned bits placed on the lanes
  function automatic logic [3:0] fl_put(logic [3:0] v, logic [2:0] w, logic dev);
    return (w == 3'h4) ? v : (w == 3'h2) ? {2'h0, v[1:0]} : (dev ? {2'h0, v[0], 1'b0} : {3'h0, v[0]});
  endfunction : fl_put
endpackage : fl_pkg

// file: rtl/fl_link_if.sv
// serial flash link between host and device
`timescale 1ns/100ps
interface fl_link_if;
  logic sck;
  logic cs_n;
  logic [3:0] h_o;
  logic [3:0] h_oe_n;
  logic [3:0] d_o;
  logic [3:0] d_oe_n;
  logic [3:0] dq;
  // =====================================================
  // wire level; undriven lanes read high as if pulled up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dq[i] = !h_oe_n[i] ? h_o[i] : (!d_oe_n[i] ? d_o[i] : 1'b1);
    end
  end
  modport host (output sck, output cs_n, output h_o, output h_oe_n, input dq);
  modport dev (input sck, input cs_n, input dq, output d_o, output d_oe_n);
endinterface : fl_link_if

// file: rtl/fl_dev.sv
// serial flash device end: lanes, status protection and address decode
// What this block does
// - frozen status ignores status writes when protected
// - write-protect pin becomes lane 2 in quad
// - single lane: in on 0, out on 1
// - dual: lanes 1:0 bidirectional, 3:2 carry write-protect and pause
// - quad: all four lanes bidirectional
// - 4KB subsector index from address bits 24:12
// - 64KB sector index from address bits 24:16
// - 32KB subsector index from address bits 24:15
// - subsector 0 covers bytes 0 through FFFh
// - status bit 7 with pin gates writes
// - pause disabled in quad protocol or DTR
`timescale 1ns/100ps
module fl_dev
  import fl_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [1:0] PROTO,
  input wire logic DTR_EN,
  fl_link_if.dev lk,
  output logic [7:0] STATUS,
  output logic [ADDR_W-1:0] ADDR,
  output logic [ADDR_W-SECTOR_LSB-1:0] SECTOR,
  output logic [ADDR_W-SUB32_LSB-1:0] SUB32,
  output logic [ADDR_W-SUB4_LSB-1:0] SUB4,
  output logic UPD
);
  // =====================================================
  // system side mode register
  logic [2:0] mode_reg;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) mode_reg <= 3'h0;
    else mode_reg <= {DTR_EN, PROTO};
  end

  // =====================================================
  // mode synchroniser into the link clock
  logic [2:0] mode_s1_reg;
  logic [2:0] mode_s2_reg;
  always_ff @(posedge lk.sck or negedge RSTN) begin
    if (!RSTN) begin
      mode_s1_reg <= 3'h0;
      mode_s2_reg <= 3'h0;
    end else begin
      mode_s1_reg <= mode_reg;
      mode_s2_reg <= mode_s1_reg;
    end
  end

  // =====================================================
  // per-edge decode of the frame
  fl_phase_e ph_reg;
  logic [5:0] nbit_reg;
  logic [31:0] sh_reg;
  logic [7:0] op_reg;
  logic [7:0] status_reg;
  logic [2:0] w;
  logic [31:0] sh_next;
  logic [5:0] nbit_next;
  logic unit_done;
  logic held;
  logic active;
  logic wp_low;
  logic four;
  always_comb begin
    four = (mode_s2_reg[1:0] == FOUR_LANE_PROTOCOL);
    w = fl_width(mode_s2_reg[1:0], op_reg, ph_reg);
    sh_next = 32'(sh_reg << w) | 32'(fl_pick(lk.dq, w, 1'b0));
    nbit_next = nbit_reg + 6'(w);
    unit_done = (ph_reg == PH_CMD || ph_reg == PH_ADDR || ph_reg == PH_DIN) && nbit_next == fl_unit_bits(ph_reg);
    held = !four && !mode_s2_reg[2] && w != 3'h4 && !lk.dq[3];
    active = !lk.cs_n && !held;
    wp_low = (w != 3'h4) && !lk.dq[2];
  end

  // =====================================================
  // frame state, cleared while select is high
  always_ff @(posedge lk.sck or posedge lk.cs_n) begin
    if (lk.cs_n) begin
      ph_reg <= PH_CMD;
      nbit_reg <= 6'h00;
      sh_reg <= 32'h0;
      op_reg <= 8'h00;
    end else if (active && (ph_reg == PH_CMD || ph_reg == PH_ADDR || ph_reg == PH_DIN)) begin
      sh_reg <= sh_next;
      if (unit_done) begin
        nbit_reg <= 6'h00;
        case (ph_reg)
          PH_CMD: begin
            op_reg <= sh_next[7:0];
            ph_reg <= fl_after_cmd(sh_next[7:0]);
          end
          PH_ADDR: ph_reg <= PH_DOUT;
          default: ph_reg <= PH_DONE;
        endcase
      end else begin
        nbit_reg <= nbit_next;
      end
    end
  end

  // =====================================================
  // status register, captured address and update toggle
  logic [ADDR_W-1:0] addr_lk_reg;
  logic upd_tgl_reg;
  always_ff @(posedge lk.sck or negedge RSTN) begin
    if (!RSTN) begin
      status_reg <= SR_RESET;
      addr_lk_reg <= '0;
      upd_tgl_reg <= 1'b0;
    end else if (active && unit_done) begin
      if (ph_reg == PH_CMD && sh_next[7:0] == OP_WRITE_ENABLE) begin
        status_reg[SR_WEL_BIT] <= 1'b1;
        upd_tgl_reg <= !upd_tgl_reg;
      end else if (ph_reg == PH_ADDR) begin
        addr_lk_reg <= sh_next[ADDR_W-1:0];
        upd_tgl_reg <= !upd_tgl_reg;
      end else if (ph_reg == PH_DIN && status_reg[SR_WEL_BIT]) begin
        if (!(status_reg[SR_SRWD_BIT] && wp_low)) begin
          status_reg <= sh_next[7:0] & SR_NV_MASK;
          upd_tgl_reg <= !upd_tgl_reg;
        end
      end
    end
  end

  // =====================================================
  // read data driven on the falling link edge
  logic [3:0] d_o_reg;
  logic [3:0] d_oe_n_reg;
  logic [3:0] ob_reg;
  logic [7:0] idx_reg;
  logic [7:0] tx_reg;
  logic [7:0] cur;
  always_comb begin
    if (ob_reg != 4'h0) cur = tx_reg;
    else if (op_reg == OP_READ_STATUS) cur = status_reg;
    else cur = addr_lk_reg[7:0] + idx_reg; // stand-in array content
  end
  always_ff @(negedge lk.sck or posedge lk.cs_n) begin
    if (lk.cs_n) begin
      d_o_reg <= 4'h0;
      d_oe_n_reg <= 4'hf;
      ob_reg <= 4'h0;
      idx_reg <= 8'h00;
      tx_reg <= 8'h00;
    end else if (ph_reg == PH_DOUT && !held) begin
      d_o_reg <= fl_put(4'(cur[7:4] >> (3'h4 - w)), w, 1'b1);
      d_oe_n_reg <= ~fl_mask(w, 1'b1);
      tx_reg <= 8'(cur << w);
      if (ob_reg + 4'(w) == 4'(BYTE_BITS)) begin
        ob_reg <= 4'h0;
        idx_reg <= idx_reg + 8'h01;
      end else begin
        ob_reg <= ob_reg + 4'(w);
      end
    end else begin
      d_oe_n_reg <= 4'hf; // released while paused or not reading
    end
  end
  assign lk.d_o = d_o_reg;
  assign lk.d_oe_n = d_oe_n_reg;

  // =====================================================
  // update toggle synchroniser into the system clock
  logic tg_s1_reg;
  logic tg_s2_reg;
  logic tg_s3_reg;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tg_s1_reg <= 1'b0;
      tg_s2_reg <= 1'b0;
      tg_s3_reg <= 1'b0;
    end else begin
      tg_s1_reg <= upd_tgl_reg;
      tg_s2_reg <= tg_s1_reg;
      tg_s3_reg <= tg_s2_reg;
    end
  end

  // =====================================================
  // system side copy and address decode
  logic [7:0] status_o_reg;
  logic [ADDR_W-1:0] addr_o_reg;
  logic [ADDR_W-SECTOR_LSB-1:0] sector_reg;
  logic [ADDR_W-SUB32_LSB-1:0] sub32_reg;
  logic [ADDR_W-SUB4_LSB-1:0] sub4_reg;
  logic upd_reg;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      status_o_reg <= SR_RESET;
      addr_o_reg <= '0;
      sector_reg <= '0;
      sub32_reg <= '0;
      sub4_reg <= '0;
      upd_reg <= 1'b0;
    end else begin
      upd_reg <= tg_s2_reg != tg_s3_reg;
      if (tg_s2_reg != tg_s3_reg) begin
        status_o_reg <= status_reg;
        addr_o_reg <= addr_lk_reg;
        sector_reg <= addr_lk_reg[ADDR_W-1:SECTOR_LSB];
        sub32_reg <= addr_lk_reg[ADDR_W-1:SUB32_LSB];
        sub4_reg <= addr_lk_reg[ADDR_W-1:SUB4_LSB];
      end
    end
  end
  assign STATUS = status_o_reg;
  assign ADDR = addr_o_reg;
  assign SECTOR = sector_reg;
  assign SUB32 = sub32_reg;
  assign SUB4 = sub4_reg;
  assign UPD = upd_reg;
endmodule : fl_dev

// file: rtl/fl_host.sv
// serial flash host controller end with its register port
`timescale 1ns/100ps
module fl_host
  import fl_pkg::*;
#(
  parameter int HALF = 4
)
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  fl_link_if.host lk
);
  if (HALF < 4 || HALF > 255) begin : g_chk
    $error("HALF must be 4 to 255");
  end
  typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_RUN = 2'b01, HS_END = 2'b10} fl_hs_e;
  fl_hs_e st_reg;
  logic [4:0] cfg_reg;
  logic [7:0] op_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdo_reg;
  logic go;
  assign go = REG_WR && REG_ADDR == RG_CMD && st_reg == HS_IDLE;

  // =====================================================
  // register writes; commands while busy are dropped
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_reg <= 5'h04;
      op_reg <= 8'h00;
      addr_reg <= '0;
      wdata_reg <= 8'h00;
    end else if (REG_WR) begin
      if (go) op_reg <= REG_WDATA[7:0];
      if (REG_ADDR == RG_ADDR) addr_reg <= REG_WDATA[ADDR_W-1:0];
      if (REG_ADDR == RG_WDATA) wdata_reg <= REG_WDATA[7:0];
      if (REG_ADDR == RG_CFG) cfg_reg <= REG_WDATA[4:0];
    end
  end

  // =====================================================
  // register reads, data one cycle after the strobe
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) rdo_reg <= 32'h0;
    else if (REG_RD) begin
      case (REG_ADDR)
        RG_CMD: rdo_reg <= {24'h0, op_reg};
        RG_ADDR: rdo_reg <= {7'h0, addr_reg};
        RG_WDATA: rdo_reg <= {24'h0, wdata_reg};
        RG_CFG: rdo_reg <= {27'h0, cfg_reg};
        RG_STAT: rdo_reg <= {31'h0, st_reg != HS_IDLE};
        RG_RDATA: rdo_reg <= rdata_reg;
        default: rdo_reg <= 32'h0;
      endcase
    end
  end
  assign REG_RDATA = rdo_reg;

  // =====================================================
  // lane synchroniser
  logic [3:0] dq_s1_reg;
  logic [3:0] dq_s2_reg;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dq_s1_reg <= 4'hf;
      dq_s2_reg <= 4'hf;
    end else begin
      dq_s1_reg <= lk.dq;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // =====================================================
  // lane plan for the current phase
  fl_phase_e ph_reg;
  logic [5:0] nbit_reg;
  logic [31:0] tx_reg;
  logic [31:0] rsh_reg;
  logic [1:0] bc_reg;
  logic [7:0] div_reg;
  logic sck_reg;
  logic cs_n_reg;
  logic [3:0] h_o_reg;
  logic [3:0] h_oe_n_reg;
  logic [2:0] w;
  logic [2:0] w0;
  logic [5:0] nbit_next;
  logic tick;
  logic [3:0] idle_m;
  logic [3:0] idle_v;
  always_comb begin
    w = fl_width(cfg_reg[1:0], op_reg, ph_reg);
    w0 = fl_width(cfg_reg[1:0], REG_WDATA[7:0], PH_CMD);
    nbit_next = nbit_reg + 6'(w);
    tick = div_reg == 8'(HALF - 1);
    // write-protect level on lane 2, pause inactive on lane 3
    idle_m = (w == 3'h4) ? 4'h0 : 4'hc;
    idle_v = {1'b1, cfg_reg[CFG_WP_BIT], 2'h0};
  end

  // =====================================================
  // frame sequencer and divided link clock
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_reg <= HS_IDLE;
      ph_reg <= PH_CMD;
      nbit_reg <= 6'h00;
      tx_reg <= 32'h0;
      rsh_reg <= 32'h0;
      rdata_reg <= 32'h0;
      bc_reg <= 2'h0;
      div_reg <= 8'h00;
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      h_o_reg <= 4'hc;
      h_oe_n_reg <= 4'h3;
    end else begin
      div_reg <= (st_reg == HS_IDLE || tick) ? 8'h00 : div_reg + 8'h01;
      case (st_reg)
        HS_IDLE: begin
          h_oe_n_reg <= ~idle_m;
          h_o_reg <= idle_v;
          if (go) begin
            st_reg <= HS_RUN;
            cs_n_reg <= 1'b0;
            ph_reg <= PH_CMD;
            nbit_reg <= 6'h00;
            bc_reg <= 2'h0;
            h_o_reg <= fl_put(4'(REG_WDATA[7:4] >> (3'h4 - w0)), w0, 1'b0) | (idle_v & ~fl_mask(w0, 1'b0));
            h_oe_n_reg <= ~(fl_mask(w0, 1'b0) | ((w0 == 3'h4) ? 4'h0 : 4'hc));
            tx_reg <= {8'(REG_WDATA[7:0] << w0), 24'h0};
          end
        end
        HS_RUN: begin
          if (tick && !sck_reg) begin
            sck_reg <= 1'b1;
            if (ph_reg == PH_DOUT) rsh_reg <= 32'(rsh_reg << w) | 32'(fl_pick(dq_s2_reg, w, 1'b1));
            if (ph_reg != PH_DONE && nbit_next == fl_unit_bits(ph_reg)) begin
              nbit_reg <= 6'h00;
              case (ph_reg)
                PH_CMD: begin
                  ph_reg <= fl_after_cmd(op_reg);
                  tx_reg <= (fl_after_cmd(op_reg) == PH_ADDR) ? {7'h0, addr_reg} : {wdata_reg, 24'h0};
                end
                PH_ADDR: ph_reg <= PH_DOUT;
                PH_DOUT: begin
                  bc_reg <= bc_reg + 2'h1;
                  if (bc_reg == cfg_reg[4:CFG_LEN_LSB]) begin
                    ph_reg <= PH_DONE;
                    rdata_reg <= 32'(rsh_reg << w) | 32'(fl_pick(dq_s2_reg, w, 1'b1));
                  end
                end
                default: ph_reg <= PH_DONE;
              endcase
            end else begin
              nbit_reg <= nbit_next;
            end
          end else if (tick) begin
            sck_reg <= 1'b0;
            if (ph_reg == PH_DONE) begin
              st_reg <= HS_END; // lanes kept as they are: after a read phase the device drives until select rises
            end else if (ph_reg == PH_DOUT) begin
              h_oe_n_reg <= ~idle_m; // lanes handed to the device
              h_o_reg <= idle_v;
            end else begin
              h_o_reg <= fl_put(4'(tx_reg[31:28] >> (3'h4 - w)), w, 1'b0) | (idle_v & ~fl_mask(w, 1'b0));
              h_oe_n_reg <= ~(fl_mask(w, 1'b0) | idle_m);
              tx_reg <= 32'(tx_reg << w);
            end
          end
        end
        HS_END: begin
          if (tick) begin
            cs_n_reg <= 1'b1;
            st_reg <= HS_IDLE;
          end
        end
        default: st_reg <= HS_IDLE;
      endcase
    end
  end
  assign lk.sck = sck_reg;
  assign lk.cs_n = cs_n_reg;
  assign lk.h_o = h_o_reg;
  assign lk.h_oe_n = h_oe_n_reg;
endmodule : fl_host

// file: tb/fl_link_properties.sv
// concurrent checks on the flash link lanes, status freeze and address decode
`timescale 1ns/100ps
module fl_link_chk
  import fl_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [1:0] PROTO,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] h_o,
  input wire logic [3:0] h_oe_n,
  input wire logic [3:0] d_oe_n,
  input wire logic [7:0] STATUS,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [ADDR_W-SECTOR_LSB-1:0] SECTOR,
  input wire logic [ADDR_W-SUB32_LSB-1:0] SUB32,
  input wire logic [ADDR_W-SUB4_LSB-1:0] SUB4,
  input wire logic UPD
);
  default clocking dc @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);
  // =====================================================
  // lane ownership per width
  property p_no_contention;
    (~h_oe_n & ~d_oe_n) == 4'h0;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("host and device drive one lane");
  property p_dev_single;
    !d_oe_n[0] |-> !d_oe_n[1];
  endproperty
  a_dev_single: assert property (p_dev_single) else $error("device drives lane 0 alone");
  property p_ext_start;
    $fell(cs_n) && PROTO == EXTENDED_LANE_PROTOCOL |-> h_oe_n[1:0] == 2'b10 && !sck;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("single lane command not on lane 0");
  property p_two_lane;
    PROTO == TWO_LANE_PROTOCOL |-> d_oe_n[3:2] == 2'b11;
  endproperty
  a_two_lane: assert property (p_two_lane) else $error("upper lanes driven in two lane mode");
  property p_four_lane;
    PROTO == FOUR_LANE_PROTOCOL && !d_oe_n[1] |-> d_oe_n == 4'h0;
  endproperty
  a_four_lane: assert property (p_four_lane) else $error("four lane output not on all lanes");
  property p_upper_pair;
    d_oe_n[2] == d_oe_n[3];
  endproperty
  a_upper_pair: assert property (p_upper_pair) else $error("lanes 2 and 3 enabled apart");
  // =====================================================
  // status freeze and decode
  property p_sr_frozen;
    STATUS[SR_SRWD_BIT] && !h_oe_n[2] && !h_o[2] && PROTO != FOUR_LANE_PROTOCOL |=> $stable(STATUS & SR_NV_MASK);
  endproperty
  a_sr_frozen: assert property (p_sr_frozen) else $error("frozen status bits changed");
  property p_sub4;
    UPD |=> SUB4 == ADDR[ADDR_W-1:SUB4_LSB];
  endproperty
  a_sub4: assert property (p_sub4) else $error("4KB index wrong");
  property p_sector;
    UPD |=> SECTOR == ADDR[ADDR_W-1:SECTOR_LSB];
  endproperty
  a_sector: assert property (p_sector) else $error("sector index wrong");
  property p_sub32;
    UPD |=> SUB32 == ADDR[ADDR_W-1:SUB32_LSB];
  endproperty
  a_sub32: assert property (p_sub32) else $error("32KB index wrong");
  property p_low;
    UPD ##1 ADDR < 25'h0001000 |-> SUB4 == 13'h0000 && SUB32 == 10'h000 && SECTOR == 9'h000;
  endproperty
  a_low: assert property (p_low) else $error("lowest unit decoded wrong");
  // main scenarios seen
  c_quad: cover property (!d_oe_n[3]);
  c_two: cover property (PROTO == TWO_LANE_PROTOCOL && !d_oe_n[1]);
  c_frozen: cover property (STATUS[SR_SRWD_BIT] && !h_oe_n[2] && !h_o[2] && !cs_n);
endmodule : fl_link_chk

// file: tb/flash_io_lanes_and_address_map_tb_top.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/100ps
module flash_io_lanes_and_address_map_tb_top;
  import fl_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b1;
  logic [1:0] proto = 2'h0;
  logic dtr_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] status;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-SECTOR_LSB-1:0] sector;
  logic [ADDR_W-SUB32_LSB-1:0] sub32;
  logic [ADDR_W-SUB4_LSB-1:0] sub4;
  logic upd;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int nclk = 0;
  // corner addresses and their documented unit numbers
  logic [24:0] cor [6] = '{25'h1fff000, 25'h1ffffff, 25'h0ff0000, 25'h0008000, 25'h0000000, 25'h0000fff};
  logic [12:0] c4 [6] = '{13'h1fff, 13'h1fff, 13'h0ff0, 13'h0008, 13'h0000, 13'h0000};
  logic [9:0] c32 [6] = '{10'h3ff, 10'h3ff, 10'h1fe, 10'h001, 10'h000, 10'h000};
  logic [8:0] cs [6] = '{9'h1ff, 9'h1ff, 9'h0ff, 9'h000, 9'h000, 9'h000};
  logic [7:0] ops [4] = '{OP_READ, OP_DUAL_IO_READ, OP_QUAD_OUTPUT_FAST_READ, OP_QUAD_IO_FAST_READ};
  fl_link_if lk ();
  fl_host fl_host_i (.SYS_CLK(sys_clk), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .lk(lk.host));
  fl_dev fl_dev_i (.SYS_CLK(sys_clk), .RSTN(rstn), .PROTO(proto), .DTR_EN(dtr_en), .lk(lk.dev),
    .STATUS(status), .ADDR(addr), .SECTOR(sector), .SUB32(sub32), .SUB4(sub4), .UPD(upd));
  fl_link_chk fl_link_chk_i (.SYS_CLK(sys_clk), .RSTN(rstn), .PROTO(proto), .sck(lk.sck), .cs_n(lk.cs_n),
    .h_o(lk.h_o), .h_oe_n(lk.h_oe_n), .d_oe_n(lk.d_oe_n), .STATUS(status), .ADDR(addr), .SECTOR(sector),
    .SUB32(sub32), .SUB4(sub4), .UPD(upd));
  // =====================================================
  // clock, link clock count and hang guard
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  always @(negedge lk.cs_n) nclk = 0;
  always @(posedge lk.sck) nclk = nclk + 1;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      print_verdict();
    end
  end
  // =====================================================
  // helpers
  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // start a frame and poll busy until it ends
  task automatic run(input logic [7:0] op);
    logic [31:0] s;
    wr(RG_CMD, {24'h0, op});
    s = 32'h1;
    for (int i = 0; i < 400 && s[0] !== 1'b0; i++) rd(RG_STAT, s);
    chk("frame end", 32'h0, {31'h0, s[0]});
  endtask : run
  task automatic cfg(input logic [1:0] p, input logic wp, input logic [1:0] lm1);
    wr(RG_CFG, {27'h0, lm1, wp, p});
  endtask : cfg
  // new device protocol, settled by a harmless frame
  task automatic set_proto(input logic [1:0] p);
    @(posedge sys_clk);
    proto <= p;
    dtr_en <= 1'($urandom);
    cfg(EXTENDED_LANE_PROTOCOL, 1'b1, 2'h0);
    run(8'h00);
  endtask : set_proto
  function automatic int nclk_exp(input logic [1:0] p, input logic [7:0] op, input logic [1:0] lm1);
    int w;
    int wa;
    int wd;
    w = (p == TWO_LANE_PROTOCOL) ? 2 : (p == FOUR_LANE_PROTOCOL) ? 4 : 1;
    wa = (op == OP_DUAL_IO_READ) ? 2 : (op == OP_QUAD_IO_FAST_READ) ? 4 : 1;
    wd = (op == OP_DUAL_IO_READ) ? 2 : (op == OP_READ) ? 1 : 4;
    if (w > 1) begin
      wa = w;
      wd = w;
    end
    return 8 / w + 32 / wa + 8 * (lm1 + 1) / wd;
  endfunction : nclk_exp
  // one read frame with data, clock count and decode checks
  task automatic rtest(input logic [1:0] p, input logic [7:0] op, input logic [24:0] a, input logic [1:0] lm1);
    logic [31:0] d;
    logic [31:0] e;
    logic [31:0] m;
    cfg(p, 1'b1, lm1);
    wr(RG_ADDR, {7'h0, a});
    run(op);
    e = 32'h0;
    for (int n = 0; n <= lm1; n++) e = {e[23:0], a[7:0] + 8'(n)};
    m = 32'hffffffff >> (8 * (3 - lm1));
    rd(RG_RDATA, d);
    chk("read data", e, d & m);
    chk("frame clocks", 32'(nclk_exp(p, op, lm1)), 32'(nclk));
    chk("sector", 32'(a[24:16]), 32'(sector));
    chk("sub32", 32'(a[24:15]), 32'(sub32));
    chk("sub4", 32'(a[24:12]), 32'(sub4));
    chk("addr", 32'(a), 32'(addr));
  endtask : rtest
  // =====================================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [7:0] ex;
    logic [7:0] w1;
    logic [24:0] a;
    void'($urandom(88382));
    rstn <= 1'b0; // falling edge at time zero, so link-side registers reset too
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    // good status write, then frozen by bit 7 with protect level low
    w1 = 8'($urandom) | 8'h80;
    wr(RG_WDATA, {24'h0, w1});
    run(OP_WRITE_ENABLE);
    chk("status wel", 32'h2, 32'(status));
    run(OP_WRITE_STATUS);
    ex = w1 & SR_NV_MASK;
    chk("status write", 32'(ex), 32'(status));
    cfg(EXTENDED_LANE_PROTOCOL, 1'b0, 2'h0);
    wr(RG_WDATA, {24'h0, ~w1});
    run(OP_WRITE_ENABLE);
    run(OP_WRITE_STATUS);
    run(OP_READ_STATUS);
    rd(RG_RDATA, d);
    chk("frozen status", 32'(ex | 8'h02), {24'h0, d[7:0]});
    chk("frozen port", 32'(ex | 8'h02), 32'(status));
    rd(8'h20, d);
    chk("unmapped", 32'h0, d);
    // reads over every protocol, all read commands in extended only, corners first
    for (int p = 0; p < 3; p++) begin
      if (p > 0) set_proto(2'(p));
      for (int i = 0; i < 8; i++) begin
        a = (i < 6) ? cor[i] : 25'($urandom);
        for (int k = 0; k < 4; k++) begin
          if (p == 0 || k == 0) rtest(2'(p), ops[k], a, 2'($urandom));
        end
        if (p == 0 && i < 6) begin
          chk("corner sub4", 32'(c4[i]), 32'(sub4));
          chk("corner sub32", 32'(c32[i]), 32'(sub32));
          chk("corner sector", 32'(cs[i]), 32'(sector));
        end
      end
    end
    // four lane protocol: lane 2 is data, so no freeze
    cfg(FOUR_LANE_PROTOCOL, 1'b0, 2'h0);
    wr(RG_WDATA, 32'h0);
    run(OP_WRITE_ENABLE);
    run(OP_WRITE_STATUS);
    chk("four lane status", 32'h0, 32'(status));
    print_verdict();
  end
endmodule : flash_io_lanes_and_address_map_tb_top
